// ===== sps_i2c_master_model.sv
/*
 * Behavioural two-wire bus master facing the slave.
 * Assumes the bench resolves both lines with pull-ups; this model only pulls low.
 */
`timescale 1ns/1ns
module sps_i2c_master_model (
	// resolved line levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	// open-drain pulls, low pulls the line
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	// ==========================================================================
	// bus conditions
	initial begin
		scl_oe_n = 1'h1;
		sda_oe_n = 1'h1;
	end

	// start: sda falls while scl rests high, then scl is pulled low
	task automatic start_cond();
		sda_oe_n = 1'h1;
		#200 sda_oe_n = 1'h0;
		#200 scl_oe_n = 1'h0;
	endtask

	// stop: sda rises while scl is high; scl then stands still
	task automatic stop_cond();
		#30 sda_oe_n = 1'h0;
		#10 scl_oe_n = 1'h1;
		#200 sda_oe_n = 1'h1;
		#200;
	endtask

	// one clock; data moves late in low so a slow filter sees scl fall first
	task automatic clk_bit(input logic b, input int th, output logic s);
		#30 sda_oe_n = b;
		#10 scl_oe_n = 1'h1;
		#(th - 2) s = sda_i;
		#2 scl_oe_n = 1'h0;
	endtask

	// eight bits msb first, then the ack clock; no select line exists
	task automatic xfer(input logic [7:0] tx, input logic ack_in, input int th,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], th, rx[i]);
		end
		clk_bit(ack_in, th, ack_out);
	endtask
endmodule

// ===== sps_i2c_slave.sv
/*
 * Two-wire slave function of a shared serial port: register file on
 * Avalon-MM, scl debounce, start/stop detection, address compare,
 * slave receive and slave transmit, collision flag and interrupt.
 * Assumes pins pass through open-drain pads with external pull-ups and
 * that the remote master runs the bus clock; no clock stretching.
 */
// Decided for this implementation: the register addresses and the Avalon-MM register port.
// Operation
// R1: data write during a transfer sets collision flag and is dropped
// R2: collision flag set by hardware only; software clears it
// R3: bus lines are open drain: pull low or release, never drive high
// R4: no chip select; the slave is chosen by the transmitted address
// R5: slave only, supporting slave transmit and slave receive
// R6: optional scl glitch filter of none, 2 or 4 system clocks
// R7: standard mode needs system clock above 2, 4, 8 MHz per filter
// R8: fast mode needs system clock above 5, 10, 20 MHz per filter
// R9: one shared data register holds bytes to send and received bytes
// R10: data register is eight bits read/write with no reset value
// R11: address register holds address in bits 7..1, bit 0 plain storage
// R12: slave is selected when the received address equals its own
// R13: address register shares its location with spi control 2
// R14: control 0 enable and mode, control 1 flags, separate time-out register
// R15: mode 101 spi slave, 110 two-wire slave, 111 unused
// R16: debounce code 00 none, 01 two clocks, 1x four clocks
// R17: address match flag high on match, low on mismatch
// R18: port enable off leaves the bus pins idle and the interface inactive
// R19: scl change accepted only after stable for the filter length
`timescale 1ns/1ns
module sps_i2c_slave (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// avalon-mm register slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// interrupt
	output logic             irq,
	// two-wire bus pins, enables active low
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n
);

	// ==========================================================================
	// declarations
	sps_pkg::sps_ctrl0_t ctrl0_q;
	sps_pkg::sps_state_t state_q;
	logic       ack_q, req, wr_acc;
	logic [2:0] swbits_q;
	logic       hcf_q, address_match_flag_q, hbb_q, srw_q, rxak_q, write_collision_flag_q;
	logic [7:0] data_q, addr_q, spi2_q, toc_q, shift_q, rd_mux;
	logic [3:0] irq_st_q, irq_mask_q, irq_ev;
	logic       scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
	logic       scl_f_q, scl_fp_q, scl_rise, scl_fall, scl_hi;
	logic [2:0] deb_cnt_q, deb_len, bit_q;
	logic       start_ev, stop_ev, i2c_on, addr_last, match_ev, rx_done, tx_done;
	logic       phase_q, sda_low_q, busy, write_collision_flag_ev;
	logic [7:0] shift_in;

	// ==========================================================================
	// avalon slave: one wait state, readdata registered
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_acc          = avs_write & ack_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q) begin
				avs_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		unique case (avs_address)
			sps_pkg::OFS_CTRL0:    rd_mux = ctrl0_q; // R14
			sps_pkg::OFS_CTRL1:    rd_mux = {hcf_q, address_match_flag_q, hbb_q, swbits_q[2:1], srw_q,
				swbits_q[0], rxak_q}; // R14
			sps_pkg::OFS_DATA:     rd_mux = data_q; // R9
			// spi view shows the live collision flag in bit 1
			sps_pkg::OFS_ADDR:     rd_mux = (ctrl0_q.port_mode_select == sps_pkg::MODE_I2C_SLAVE)
				? addr_q : {spi2_q[7:2], write_collision_flag_q, spi2_q[0]}; // R13
			sps_pkg::OFS_TOC:      rd_mux = toc_q;
			sps_pkg::OFS_IRQ_ST:   rd_mux = {4'h0, irq_st_q};
			sps_pkg::OFS_IRQ_MASK: rd_mux = {4'h0, irq_mask_q};
			default:               rd_mux = 8'h00;
		endcase
	end

	// ==========================================================================
	// software registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q    <= sps_pkg::CTRL0_RST;
			swbits_q   <= sps_pkg::SWBITS_RST;
			toc_q      <= sps_pkg::TOC_RST;
			irq_mask_q <= sps_pkg::IRQ_RST;
		end else if (wr_acc) begin
			if (avs_address == sps_pkg::OFS_CTRL0) begin
				ctrl0_q      <= avs_writedata[7:0]; // R14
				ctrl0_q.rsvd <= 1'b0;
			end
			if (avs_address == sps_pkg::OFS_CTRL1) begin
				swbits_q <= {avs_writedata[4:3], avs_writedata[1]};
			end
			if (avs_address == sps_pkg::OFS_TOC) begin
				toc_q <= avs_writedata[7:0]; // R14
			end
			if (avs_address == sps_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= avs_writedata[3:0];
			end
		end
	end

	// own address and spi control 2 share one location, picked by mode
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= sps_pkg::ADDR_RST; // R11
			spi2_q <= sps_pkg::SPI2_RST;
		end else if (wr_acc && avs_address == sps_pkg::OFS_ADDR) begin
			if (ctrl0_q.port_mode_select == sps_pkg::MODE_I2C_SLAVE) begin
				addr_q <= avs_writedata[7:0]; // R11 R13
			end else begin
				spi2_q <= avs_writedata[7:0]; // R13
			end
		end
	end

	// collision flag: set wins over a software clear in the same cycle
	assign busy    = i2c_on & (state_q == sps_pkg::ST_RX || state_q == sps_pkg::ST_TX
		|| state_q == sps_pkg::ST_ADDR) & (bit_q != 3'h0);
	assign write_collision_flag_ev = wr_acc & (avs_address == sps_pkg::OFS_DATA) & busy; // R1
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			write_collision_flag_q <= 1'b0;
		end else if (write_collision_flag_ev) begin
			write_collision_flag_q <= 1'b1; // R1
		end else if (wr_acc && avs_address == sps_pkg::OFS_ADDR
			&& ctrl0_q.port_mode_select != sps_pkg::MODE_I2C_SLAVE) begin
			write_collision_flag_q <= avs_writedata[sps_pkg::WRITE_COLLISION_FLAG_BIT] & write_collision_flag_q; // R2
		end
	end

	// data register has no reset; received byte beats a late software write
	always_ff @(posedge clk) begin
		if (rx_done) begin
			data_q <= shift_in; // R9
		end else if (wr_acc && avs_address == sps_pkg::OFS_DATA && !busy) begin
			data_q <= avs_writedata[7:0]; // R1 R10
		end
	end

	// ==========================================================================
	// pin synchronisers and scl filter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// upper code bit alone selects the longest filter
	always_comb begin
		if (ctrl0_q.debounce_select[1]) begin
			deb_len = sps_pkg::DEB_LEN_4; // R16
		end else if (ctrl0_q.debounce_select == sps_pkg::DEB_SEL_2) begin
			deb_len = sps_pkg::DEB_LEN_2; // R16
		end else begin
			deb_len = sps_pkg::DEB_LEN_NONE; // R16
		end
	end

	// a glitch shorter than the filter restarts the count and is dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			deb_cnt_q <= 3'h0;
			scl_f_q   <= 1'b1;
			scl_fp_q  <= 1'b1;
		end else begin
			scl_fp_q <= scl_f_q;
			if (scl_s_q == scl_f_q) begin
				deb_cnt_q <= 3'h0; // R19
			end else if (3'(deb_cnt_q + 3'h1) >= deb_len) begin
				scl_f_q   <= scl_s_q; // R6 R19
				deb_cnt_q <= 3'h0;
			end else begin
				deb_cnt_q <= 3'(deb_cnt_q + 3'h1);
			end
		end
	end

	// start/stop only when raw and filtered scl agree high, else filter lag
	// would turn a data change just after scl falls into a false condition
	assign scl_rise  = scl_f_q & ~scl_fp_q;
	assign scl_fall  = ~scl_f_q & scl_fp_q;
	assign scl_hi    = scl_f_q & scl_s_q;
	assign i2c_on    = ctrl0_q.port_enable
		& (ctrl0_q.port_mode_select == sps_pkg::MODE_I2C_SLAVE); // R15 R18
	assign start_ev  = i2c_on & scl_hi & sda_p_q & ~sda_s_q;
	assign stop_ev   = i2c_on & scl_hi & ~sda_p_q & sda_s_q;
	assign shift_in  = {shift_q[6:0], sda_s_q};
	assign addr_last = i2c_on & (state_q == sps_pkg::ST_ADDR) & scl_rise & (bit_q == sps_pkg::LAST_BIT);
	assign match_ev  = addr_last & (shift_in[7:1] == addr_q[7:1]); // R4 R12
	assign rx_done   = i2c_on & (state_q == sps_pkg::ST_RX) & scl_rise & (bit_q == sps_pkg::LAST_BIT);
	assign tx_done   = i2c_on & (state_q == sps_pkg::ST_TX) & scl_rise & (bit_q == sps_pkg::LAST_BIT);

	// ==========================================================================
	// bus engine: address phase, slave receive, slave transmit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q   <= sps_pkg::ST_IDLE;
			bit_q     <= 3'h0;
			shift_q   <= 8'h00;
			phase_q   <= 1'b0;
			sda_low_q <= 1'b0;
			rxak_q    <= sps_pkg::RXAK_RST;
		end else if (!i2c_on) begin
			state_q   <= sps_pkg::ST_IDLE; // R18
			sda_low_q <= 1'b0;
			phase_q   <= 1'b0;
			rxak_q    <= sps_pkg::RXAK_RST;
		end else if (start_ev || stop_ev) begin
			state_q   <= start_ev ? sps_pkg::ST_ADDR : sps_pkg::ST_IDLE;
			bit_q     <= 3'h0;
			phase_q   <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			unique case (state_q)
				sps_pkg::ST_IDLE, sps_pkg::ST_IGNORE: begin
					sda_low_q <= 1'b0;
				end
				sps_pkg::ST_ADDR, sps_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_q <= shift_in;
						bit_q   <= 3'(bit_q + 3'h1);
						if (bit_q == sps_pkg::LAST_BIT) begin
							if (state_q == sps_pkg::ST_RX) begin
								state_q <= sps_pkg::ST_RX_ACK; // R5
							end else begin
								state_q <= match_ev ? sps_pkg::ST_ADDR_ACK : sps_pkg::ST_IGNORE; // R4
							end
						end
					end
				end
				sps_pkg::ST_ADDR_ACK, sps_pkg::ST_RX_ACK: begin
					if (scl_fall && !phase_q) begin
						phase_q   <= 1'b1;
						sda_low_q <= (state_q == sps_pkg::ST_ADDR_ACK) | ~swbits_q[1];
					end else if (scl_fall) begin
						phase_q <= 1'b0;
						bit_q   <= 3'h0;
						if (state_q == sps_pkg::ST_ADDR_ACK && srw_q) begin
							state_q   <= sps_pkg::ST_TX; // R5
							shift_q   <= data_q; // R9
							sda_low_q <= ~data_q[7]; // R3
						end else begin
							state_q   <= sps_pkg::ST_RX; // R5
							sda_low_q <= 1'b0;
						end
					end
				end
				sps_pkg::ST_TX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], 1'b0};
						bit_q   <= 3'(bit_q + 3'h1);
						if (bit_q == sps_pkg::LAST_BIT) begin
							state_q <= sps_pkg::ST_TX_ACK;
						end
					end else if (scl_fall) begin
						sda_low_q <= ~shift_q[7]; // R3
					end
				end
				sps_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						phase_q <= 1'b1;
						rxak_q  <= sda_s_q;
					end else if (scl_fall && !phase_q) begin
						sda_low_q <= 1'b0;
					end else if (scl_fall) begin
						phase_q <= 1'b0;
						bit_q   <= 3'h0;
						if (!rxak_q) begin
							state_q   <= sps_pkg::ST_TX; // R5
							shift_q   <= data_q;
							sda_low_q <= ~data_q[7];
						end else begin
							state_q   <= sps_pkg::ST_IGNORE;
							sda_low_q <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// hardware status flags of control 1
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hcf_q  <= sps_pkg::HCF_RST;
			address_match_flag_q <= 1'b0;
			hbb_q  <= 1'b0;
			srw_q  <= 1'b0;
		end else if (!i2c_on) begin
			hcf_q  <= sps_pkg::HCF_RST; // R18
			address_match_flag_q <= 1'b0;
			hbb_q  <= 1'b0;
			srw_q  <= 1'b0;
		end else begin
			if (start_ev) begin
				hbb_q <= 1'b1;
			end else if (stop_ev) begin
				hbb_q <= 1'b0;
			end
			if (addr_last) begin
				address_match_flag_q <= match_ev; // R17
			end
			if (match_ev) begin
				srw_q <= shift_in[0];
			end
			if (match_ev || rx_done || tx_done) begin
				hcf_q <= 1'b1;
			end else if (scl_rise && bit_q == 3'h0 && (state_q == sps_pkg::ST_ADDR
				|| state_q == sps_pkg::ST_RX || state_q == sps_pkg::ST_TX)) begin
				hcf_q <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// interrupt: sticky status, write one to clear, set wins
	assign irq_ev = {stop_ev & hbb_q, write_collision_flag_ev, match_ev, match_ev | rx_done | tx_done};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_q <= sps_pkg::IRQ_RST;
		end else if (wr_acc && avs_address == sps_pkg::OFS_IRQ_ST) begin
			irq_st_q <= (irq_st_q & ~avs_writedata[3:0]) | irq_ev;
		end else begin
			irq_st_q <= irq_st_q | irq_ev;
		end
	end
	assign irq = |(irq_st_q & irq_mask_q);

	// open drain: level fixed low, only the enable moves; scl is never held
	assign scl_o    = 1'b0; // R3
	assign scl_oe_n = 1'b1; // R3
	assign sda_o    = 1'b0; // R3
	assign sda_oe_n = ~(sda_low_q & i2c_on); // R3 R18

	// ==========================================================================
	// assertions
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_write_collision_flag_sets_flag: assert property (write_collision_flag_ev |=> write_collision_flag_q) // R1
		else $error("collision write did not set flag");
	a_write_collision_flag_drops_write: assert property (write_collision_flag_ev && !rx_done |=> $stable(data_q)) // R1
		else $error("collision write changed data");
	a_write_collision_flag_sticky: assert property (write_collision_flag_q && !(wr_acc && avs_address == sps_pkg::OFS_ADDR)
		|=> write_collision_flag_q) // R2
		else $error("collision flag cleared without software");
	a_sda_open_drain: assert property (sda_o == 1'b0 && scl_oe_n) // R3
		else $error("bus line driven high or scl held");
	a_filter_two: assert property (ctrl0_q.debounce_select == sps_pkg::DEB_SEL_2
		&& $changed(scl_f_q) |-> $past(scl_s_q) == scl_f_q && $past(scl_s_q, 2) == scl_f_q) // R6
		else $error("scl accepted before two stable clocks");
	a_filter_four: assert property (ctrl0_q.debounce_select[1] && $changed(scl_f_q)
		|-> $past(scl_s_q) == scl_f_q && $past(scl_s_q, 4) == scl_f_q) // R19
		else $error("scl accepted before four stable clocks");
	a_match_flag: assert property (addr_last |=> address_match_flag_q == $past(shift_in[7:1] == addr_q[7:1])) // R17
		else $error("match flag disagrees with address compare");
	a_match_acks: assert property (match_ev |=> state_q == sps_pkg::ST_ADDR_ACK) // R12
		else $error("matched address not acknowledged");
	a_disabled_idle: assert property (!i2c_on |=> state_q == sps_pkg::ST_IDLE && sda_oe_n) // R18
		else $error("inactive port still on the bus");
	a_rx_byte_kept: assert property (rx_done |=> data_q == $past(shift_in) && hcf_q) // R9
		else $error("received byte not in data register");
	a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in one wait state");

	c_addr_match: cover property (match_ev);
	c_rx_byte: cover property (rx_done);
	c_tx_next: cover property (state_q == sps_pkg::ST_TX_ACK ##1 state_q == sps_pkg::ST_TX);
	c_collision: cover property (write_collision_flag_ev);

endmodule

// ===== sps_pkg.sv
/*
 * Shared constants and types of the serial port two-wire slave:
 * register byte offsets, reset values, mode and debounce codes,
 * register field layouts and the bus engine states.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
package sps_pkg;

	// ==========================================================================
	// register byte offsets
	localparam logic [4:0] OFS_CTRL0    = 5'h00;
	localparam logic [4:0] OFS_CTRL1    = 5'h04;
	localparam logic [4:0] OFS_DATA     = 5'h08;
	localparam logic [4:0] OFS_ADDR     = 5'h0C;
	localparam logic [4:0] OFS_TOC      = 5'h10;
	localparam logic [4:0] OFS_IRQ_ST   = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

	// ==========================================================================
	// values after reset
	localparam logic [7:0] CTRL0_RST    = 8'hE0;
	localparam logic       HCF_RST      = 1'b1;
	localparam logic       RXAK_RST     = 1'b1;
	localparam logic [2:0] SWBITS_RST   = 3'h0;
	localparam logic [7:0] ADDR_RST     = 8'h00;
	localparam logic [7:0] SPI2_RST     = 8'h00;
	localparam logic [7:0] TOC_RST      = 8'h00;
	localparam logic [3:0] IRQ_RST      = 4'h0;

	// ==========================================================================
	// mode codes, debounce codes and lengths in system clocks
	localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
	localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
	localparam logic [2:0] MODE_UNUSED    = 3'h7;
	localparam logic [1:0] DEB_SEL_NONE   = 2'h0;
	localparam logic [1:0] DEB_SEL_2      = 2'h1;
	localparam logic [2:0] DEB_LEN_NONE   = 3'h0;
	localparam logic [2:0] DEB_LEN_2      = 3'h2;
	localparam logic [2:0] DEB_LEN_4      = 3'h4;

	// ==========================================================================
	// field positions
	localparam int WRITE_COLLISION_FLAG_BIT  = 1;
	localparam int IRQ_BYTE  = 0;
	localparam int IRQ_MATCH = 1;
	localparam int IRQ_WRITE_COLLISION_FLAG  = 2;
	localparam int IRQ_STOP  = 3;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ==========================================================================
	// register layouts and engine states
	typedef struct packed {
		logic [2:0] port_mode_select;
		logic       rsvd;
		logic [1:0] debounce_select;
		logic       port_enable;
		logic       spi_incomplete;
	} sps_ctrl0_t;

	typedef struct packed {
		logic hcf;
		logic address_match_flag;
		logic hbb;
		logic htx;
		logic txak;
		logic srw;
		logic iamwu;
		logic rxak;
	} sps_ctrl1_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
	} sps_state_t;

endpackage

// ===== tb_top.sv
/*
 * Self-checking bench of the two-wire slave: registers, interrupt, frames.
 * Assumes the package and slave compile first; pull-ups are modelled here.
 */
`timescale 1ns/1ns
module tb_top;
	// ==========================================================================
	// signals
	logic        clk;
	logic        rst_b;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        scl_o;
	logic        scl_oe_n;
	logic        sda_o;
	logic        sda_oe_n;
	logic        m_scl_oe_n;
	logic        m_sda_oe_n;
	logic        od_bad;
	logic [31:0] q;
	logic [7:0]  own;
	logic [7:0]  dat;
	logic [7:0]  rx;
	logic        ak;
	int          seed;
	int          miscompares;
	int          n_compared;
	// pull-ups: a line is low only while someone pulls it
	wire         scl_w = (scl_oe_n | scl_o) & m_scl_oe_n;
	wire         sda_w = (sda_oe_n | sda_o) & m_sda_oe_n;

	// ==========================================================================
	// instances
	sps_i2c_slave i_dut (
		.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);
	sps_i2c_master_model i_mst (
		.scl_i(scl_w), .sda_i(sda_w), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n)
	);

	// 125 MHz keeps every filter setting inside its speed margin
	always #4 clk = ~clk;

	// device may only pull sda low and never touches scl
	always @(posedge clk) begin
		if (rst_b && (scl_oe_n !== 1'h1 || scl_o !== 1'h0 || sda_o !== 1'h0)) begin
			od_bad <= 1'h1;
		end
	end

	// ==========================================================================
	// helpers
	function automatic logic [31:0] exp_rst(input logic [4:0] a);
		case (a)
			5'h00: exp_rst = 32'h000000E0;
			5'h04: exp_rst = 32'h00000081;
			default: exp_rst = 32'h00000000;
		endcase
	endfunction

	function automatic logic [7:0] c0(input logic [2:0] m, input logic [1:0] db, input logic en);
		c0 = {m, 1'h0, db, en, 1'h0};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one bus cycle; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= {24'h000000, d};
		// waitrequest and readdata are taken at the rising edge itself
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		if (n >= 50) miscompares++;
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'h0, a, 8'h00);
		check(q, exp);
	endtask

	// ==========================================================================
	// sequence
	initial begin
		clk = 1'h0;
		rst_b = 1'h0;
		avs_address = 5'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h00000000;
		od_bad = 1'h0;
		seed = 32'hEEF3;
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		// reset values; the unmapped write must leave no trace
		bus(1'h1, 5'h1C, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			if (i != 2) rdchk(5'(4 * i), exp_rst(5'(4 * i)));
		end
		// every mode and debounce code; bit 4 reads zero
		for (int i = 0; i < 12; i++) begin
			bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'(5 + i / 4), 2'(i), 1'h0) | 8'h11);
			rdchk(sps_pkg::OFS_CTRL0, {24'h0, c0(3'(5 + i / 4), 2'(i), 1'h0) | 8'h01});
		end
		own = 8'($random(seed));
		bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h6, 2'h1, 1'h1));
		bus(1'h1, sps_pkg::OFS_ADDR, own);
		rdchk(sps_pkg::OFS_ADDR, {24'h0, own});
		bus(1'h1, sps_pkg::OFS_IRQ_MASK, 8'h0F);
		// data has no reset value; give it a known one before any frame
		bus(1'h1, sps_pkg::OFS_DATA, own);
		rdchk(sps_pkg::OFS_DATA, {24'h0, own});
		// receive frames, unfiltered and two-clock; software writes mid-byte
		for (int k = 0; k < 2; k++) begin
			bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h6, 2'(k), 1'h1));
			bus(1'h1, sps_pkg::OFS_IRQ_ST, 8'h0F);
			dat = 8'($random(seed));
			i_mst.start_cond();
			i_mst.xfer({own[7:1], 1'h0}, 1'h1, 40, rx, ak);
			check({31'h0, ak}, 32'h0);
			bus(1'h0, sps_pkg::OFS_CTRL1, 8'h00);
			check({30'h0, q[6], q[2]}, 32'h2);
			fork
				i_mst.xfer(dat, 1'h1, 40, rx, ak);
				begin
					#240;
					bus(1'h1, sps_pkg::OFS_DATA, ~dat);
				end
			join
			check({31'h0, ak}, 32'h0);
			rdchk(sps_pkg::OFS_DATA, {24'h0, dat});
			i_mst.stop_cond();
			rdchk(sps_pkg::OFS_IRQ_ST, 32'h0000000F);
			check({31'h0, irq}, 32'h1);
		end
		// masking and write-one clearing of the interrupt
		bus(1'h1, sps_pkg::OFS_IRQ_MASK, 8'h00);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
		bus(1'h1, sps_pkg::OFS_IRQ_ST, 8'h05);
		rdchk(sps_pkg::OFS_IRQ_ST, 32'h0000000A);
		bus(1'h1, sps_pkg::OFS_IRQ_MASK, 8'h08);
		@(negedge clk);
		check({31'h0, irq}, 32'h1);
		bus(1'h1, sps_pkg::OFS_IRQ_ST, 8'h0A);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
		// collision stays set until software clears it in the spi view
		bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h7, 2'h1, 1'h1));
		rdchk(sps_pkg::OFS_ADDR, 32'h00000002);
		bus(1'h1, sps_pkg::OFS_ADDR, 8'h00);
		rdchk(sps_pkg::OFS_ADDR, 32'h00000000);
		bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h6, 2'h1, 1'h1));
		rdchk(sps_pkg::OFS_ADDR, {24'h0, own});
		// slave transmit of a preloaded byte twice; master acks the first, refuses the second
		dat = 8'($random(seed));
		bus(1'h1, sps_pkg::OFS_DATA, dat);
		i_mst.start_cond();
		i_mst.xfer({own[7:1], 1'h1}, 1'h1, 40, rx, ak);
		check({31'h0, ak}, 32'h0);
		bus(1'h0, sps_pkg::OFS_CTRL1, 8'h00);
		check({30'h0, q[6], q[2]}, 32'h3);
		i_mst.xfer(8'hFF, 1'h0, 40, rx, ak);
		check({24'h0, rx}, {24'h0, dat});
		i_mst.xfer(8'hFF, 1'h1, 40, rx, ak);
		check({24'h0, rx}, {24'h0, dat});
		i_mst.stop_cond();
		// foreign address: no ack, no match
		i_mst.start_cond();
		i_mst.xfer({own[7:1] ^ 7'h01, 1'h0}, 1'h1, 40, rx, ak);
		check({31'h0, ak}, 32'h1);
		bus(1'h0, sps_pkg::OFS_CTRL1, 8'h00);
		check({31'h0, q[6]}, 32'h0);
		i_mst.stop_cond();
		// four-clock filter: 16 ns clock pulses must not clock the address in
		for (int k = 2; k < 4; k++) begin
			bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h6, 2'(k), 1'h1));
			i_mst.start_cond();
			i_mst.xfer({own[7:1], 1'h0}, 1'h1, 16, rx, ak);
			check({31'h0, ak}, 32'h1);
			i_mst.stop_cond();
		end
		// disabled port ignores its own address and shows default flags
		bus(1'h1, sps_pkg::OFS_CTRL0, c0(3'h6, 2'h0, 1'h0));
		i_mst.start_cond();
		i_mst.xfer({own[7:1], 1'h0}, 1'h1, 40, rx, ak);
		check({31'h0, ak}, 32'h1);
		rdchk(sps_pkg::OFS_CTRL1, 32'h00000081);
		i_mst.stop_cond();
		check({31'h0, od_bad}, 32'h0);
		end_sim();
	end

	// hang guard: the sequence needs well under 200 us
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
